// >>> src/csp_scan_ctrl.sv
// Notes on behaviour
// - every one of the sixteen channels is selected in a repeating scan.
// - each conversion gives a 10-bit unsigned code, full scale at supply.
// - the sequencer times the front end and picks the channel converted.
// - codes are scaled and offset before reaching registers; only the touch bits are debounced.
// - each channel's baseline tracks slow drift so drift is not a touch.
// - all channels get the same calibration so any can be a switch.
// - per-channel results sit in host-readable data registers.
// - with nothing touched the block drops to low power on its own.
// - a touch in low power wakes the block back to normal scanning.
// - a wake by touch raises the interrupt output to the host.
// - a soft reset command or the shutdown pin initialises the scan logic and host settings.
// - the host reaches registers over a 2-wire serial target port.
// - shutdown low halts all operation, high lets it run.
`timescale 1ns/10ps
`default_nettype none
module csp_scan_ctrl
   import csp_pkg::*;
#(
   parameter int SLEEP_GAP = SLEEP_GAP_CYC,
   parameter int QUIET_N = QUIET_SCANS
)
(
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_SHUTDOWN_INPUT,
   input wire logic I_SCL,
   input wire logic I_SDA_I,
   output logic O_SDA_O,
   output logic O_SDA_OE,
   input wire logic I_ADDR_SEL,
   input wire logic I_ADC_DONE,
   input wire logic [CODE_W-1:0] I_ADC_CODE,
   output logic [3:0] O_CH_SEL,
   output logic O_AFE_SAMPLE,
   output logic O_ADC_START,
   output logic O_LOW_POWER,
   output logic O_INT,
   output logic [CH_NUM-1:0] O_TOUCH
);
   localparam int TW = $clog2(SLEEP_GAP + SETTLE_CYC + 1);
   localparam int QW = $clog2(QUIET_N + 1);

   csp_host_if hbus ();
   csp_scan_t st_q, st_d;
   logic [2:0] shut_s_q;
   logic run_q, srst_q, clr;
   logic [TW-1:0] tmr_q;
   logic [QW-1:0] quiet_q;
   logic [CODE_W-1:0] code_q;
   logic [CODE_W-1:0] base_q [CH_NUM];
   logic [CODE_W-1:0] delta_q [CH_NUM];
   logic [1:0] deb_q [CH_NUM];
   logic [CH_NUM-1:0] cal_q;
   logic [7:0] scale_q, offset_q, thresh_q;
   logic [CODE_W-1:0] val, dlt;
   logic [CODE_W+7:0] prod;
   logic raw, tnew;
   logic [CH_NUM-1:0] tvec;
   logic scan_end, any;

   // clamp a wider sum into the code range; a large scale must not wrap
   function automatic logic [CODE_W-1:0] sat_code(input logic [CODE_W+4:0] x);
      return (x[CODE_W+4:CODE_W] != 5'h00) ? {CODE_W{1'b1}} : x[CODE_W-1:0];
   endfunction : sat_code

   // shutdown pin: three flops, level taken when last two agree
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         shut_s_q <= 3'h0;
         run_q <= 1'b0;
      end
      else
      begin
         shut_s_q <= {shut_s_q[1:0], I_SHUTDOWN_INPUT};
         if (shut_s_q[1] == shut_s_q[2]) run_q <= shut_s_q[2];
      end

   // soft reset is registered so it lands one cycle after the write
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST) srst_q <= 1'b0;
      else srst_q <= hbus.wr_stb & (hbus.reg_ptr == RA_CTRL)
         & hbus.wdata[CTRL_SOFT_RST_BIT];
   assign clr = srst_q | ~run_q;

   csp_serial_target u_tgt (
      .i_clk(I_CLK),
      .i_nrst(I_NRST),
      .i_halt(~run_q),
      .i_scl(I_SCL),
      .i_sda(I_SDA_I),
      .i_addr_sel(I_ADDR_SEL),
      .o_sda_oe(O_SDA_OE),
      .bus(hbus)
   );
   assign O_SDA_O = 1'b0; // open drain: only the enable toggles

   // conversion arithmetic for the channel just converted
   always_comb
   begin
      prod = code_q * scale_q;
      val = sat_code({1'b0, prod[CODE_W+7:4]} + {7'h00, offset_q});
      dlt = (val > base_q[O_CH_SEL]) ? val - base_q[O_CH_SEL] : '0;
      raw = cal_q[O_CH_SEL] & (dlt > {2'b00, thresh_q});
      tnew = O_TOUCH[O_CH_SEL];
      if (raw != O_TOUCH[O_CH_SEL]
         && deb_q[O_CH_SEL] == 2'(DEBOUNCE_N - 1))
         tnew = raw;
      tvec = O_TOUCH;
      tvec[O_CH_SEL] = tnew;
      any = |tvec;
      scan_end = (st_q == SC_PROCESS) && (O_CH_SEL == 4'(CH_NUM - 1));
   end

   // scan sequencer
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         SC_SETTLE: if (tmr_q == TW'(SETTLE_CYC - 1)) st_d = SC_CONVERT;
         SC_CONVERT: st_d = SC_WAIT;
         SC_WAIT: if (I_ADC_DONE) st_d = SC_PROCESS;
         SC_PROCESS:
            if (scan_end && O_LOW_POWER && !any) st_d = SC_SLEEP;
            else if (scan_end && !any && quiet_q == QW'(QUIET_N - 1))
               st_d = SC_SLEEP;
            else st_d = SC_SETTLE;
         SC_SLEEP: if (tmr_q == TW'(SLEEP_GAP - 1)) st_d = SC_SETTLE;
         default: st_d = SC_SETTLE;
      endcase
   end

   // state, timer and registered front end controls
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         st_q <= SC_SETTLE;
         tmr_q <= '0;
         O_AFE_SAMPLE <= 1'b0;
         O_ADC_START <= 1'b0;
         code_q <= '0;
      end
      else if (clr)
      begin
         st_q <= SC_SETTLE;
         tmr_q <= '0;
         O_AFE_SAMPLE <= 1'b0;
         O_ADC_START <= 1'b0;
         code_q <= '0;
      end
      else
      begin
         st_q <= st_d;
         // after a clear the settle count waits for the sample line
         tmr_q <= (st_d != st_q || st_q == SC_SETTLE && !O_AFE_SAMPLE) ? '0
            : tmr_q + TW'(1);
         O_AFE_SAMPLE <= (st_d == SC_SETTLE);
         O_ADC_START <= (st_d == SC_CONVERT);
         if (st_q == SC_WAIT && I_ADC_DONE) code_q <= I_ADC_CODE;
      end

   // channel select steps once per processed conversion
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST) O_CH_SEL <= 4'h0;
      else if (clr) O_CH_SEL <= 4'h0;
      else if (st_q == SC_PROCESS) O_CH_SEL <= O_CH_SEL + 4'h1;

   // per-channel debounce, baseline tracking and result storage
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         O_TOUCH <= '0;
         cal_q <= '0;
         for (int i = 0; i < CH_NUM; i++)
         begin
            base_q[i] <= '0;
            delta_q[i] <= '0;
            deb_q[i] <= 2'h0;
         end
      end
      else if (clr)
      begin
         O_TOUCH <= '0;
         cal_q <= '0;
         for (int i = 0; i < CH_NUM; i++)
         begin
            base_q[i] <= '0;
            delta_q[i] <= '0;
            deb_q[i] <= 2'h0;
         end
      end
      else if (st_q == SC_PROCESS)
      begin
         O_TOUCH <= tvec;
         delta_q[O_CH_SEL] <= dlt;
         if (raw != O_TOUCH[O_CH_SEL] && tnew == O_TOUCH[O_CH_SEL])
            deb_q[O_CH_SEL] <= deb_q[O_CH_SEL] + 2'h1;
         else
            deb_q[O_CH_SEL] <= 2'h0;
         // same tracking on every channel; held while a touch is seen
         if (!cal_q[O_CH_SEL])
         begin
            base_q[O_CH_SEL] <= val;
            cal_q[O_CH_SEL] <= 1'b1;
         end
         else if (!raw && !O_TOUCH[O_CH_SEL])
         begin
            if (val > base_q[O_CH_SEL])
               base_q[O_CH_SEL] <= base_q[O_CH_SEL] + 10'h001;
            else if (val < base_q[O_CH_SEL])
               base_q[O_CH_SEL] <= base_q[O_CH_SEL] - 10'h001;
         end
      end

   // power mode and wake interrupt; a wake beats an interrupt clear write in one cycle
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         O_LOW_POWER <= 1'b0;
         O_INT <= 1'b0;
         quiet_q <= '0;
      end
      else if (clr)
      begin
         O_LOW_POWER <= 1'b0;
         O_INT <= 1'b0;
         quiet_q <= '0;
      end
      else
      begin
         if (scan_end && any)
         begin
            quiet_q <= '0;
            O_LOW_POWER <= 1'b0;
         end
         else if (scan_end && quiet_q == QW'(QUIET_N - 1))
            O_LOW_POWER <= 1'b1;
         else if (scan_end)
            quiet_q <= quiet_q + QW'(1);
         if (scan_end && any && O_LOW_POWER) O_INT <= 1'b1;
         else if (hbus.wr_stb && hbus.reg_ptr == RA_CTRL
            && hbus.wdata[CTRL_INT_CLR_BIT]) O_INT <= 1'b0;
      end

   // host writable settings
   always_ff @(posedge I_CLK or negedge I_NRST)
      if (!I_NRST)
      begin
         scale_q <= RST_SCALE;
         offset_q <= RST_OFFSET;
         thresh_q <= RST_THRESH;
      end
      else if (clr)
      begin
         scale_q <= RST_SCALE;
         offset_q <= RST_OFFSET;
         thresh_q <= RST_THRESH;
      end
      else if (hbus.wr_stb)
      begin
         if (hbus.reg_ptr == RA_SCALE) scale_q <= hbus.wdata;
         if (hbus.reg_ptr == RA_OFFSET) offset_q <= hbus.wdata;
         if (hbus.reg_ptr == RA_THRESH) thresh_q <= hbus.wdata;
      end

   // read mux; deltas lose two low bits to fit a byte
   always_comb
   begin
      hbus.rdata = 8'h00;
      if (hbus.reg_ptr < RA_TOUCH_LO)
         hbus.rdata = delta_q[hbus.reg_ptr[3:0]][CODE_W-1:2];
      else
         unique case (hbus.reg_ptr)
            RA_TOUCH_LO: hbus.rdata = O_TOUCH[7:0];
            RA_TOUCH_HI: hbus.rdata = O_TOUCH[15:8];
            RA_SCALE: hbus.rdata = scale_q;
            RA_OFFSET: hbus.rdata = offset_q;
            RA_THRESH: hbus.rdata = thresh_q;
            RA_STATUS: hbus.rdata = {O_CH_SEL, 2'b00, O_INT, O_LOW_POWER};
            default: hbus.rdata = 8'h00;
         endcase
   end
endmodule : csp_scan_ctrl
`default_nettype wire

// >>> src/csp_pkg.sv
package csp_pkg;
   // channel and converter shape
   localparam int CH_NUM = 16;
   localparam int CODE_W = 10;
   // clock: 8 ns period, 125 MHz
   localparam int CLK_PERIOD_PS = 8000;
   localparam int CYC_PER_US = 1000000 / CLK_PERIOD_PS;
   // front end settling before each conversion, rounded up
   localparam int SETTLE_NS = 1000;
   localparam int SETTLE_CYC = (SETTLE_NS * CYC_PER_US + 999) / 1000;
   // gap between scans while in low power
   localparam int SLEEP_GAP_US = 10000;
   localparam int SLEEP_GAP_CYC = SLEEP_GAP_US * CYC_PER_US;
   // untouched full scans before low power, and debounce length
   localparam int QUIET_SCANS = 8;
   localparam int DEBOUNCE_N = 3;
   // 2-wire target address, low bit from the select pin
   localparam logic [6:0] TGT_ADDR_BASE = 7'h5C;
   // register offsets on the serial bus
   localparam logic [7:0] RA_DELTA_BASE = 8'h00;
   localparam logic [7:0] RA_TOUCH_LO = 8'h10;
   localparam logic [7:0] RA_TOUCH_HI = 8'h11;
   localparam logic [7:0] RA_CTRL = 8'h12;
   localparam logic [7:0] RA_SCALE = 8'h13;
   localparam logic [7:0] RA_OFFSET = 8'h14;
   localparam logic [7:0] RA_THRESH = 8'h15;
   localparam logic [7:0] RA_STATUS = 8'h16;
   // control bit positions
   localparam int CTRL_SOFT_RST_BIT = 0;
   localparam int CTRL_INT_CLR_BIT = 1;
   // values after reset
   localparam logic [7:0] RST_SCALE = 8'h10;
   localparam logic [7:0] RST_OFFSET = 8'h00;
   localparam logic [7:0] RST_THRESH = 8'h20;

   typedef enum logic [2:0] {SC_SETTLE, SC_CONVERT, SC_WAIT, SC_PROCESS,
      SC_SLEEP} csp_scan_t;
   typedef enum logic [3:0] {TG_IDLE, TG_ADDR, TG_ACK_A, TG_PTR, TG_ACK_P,
      TG_WDATA, TG_ACK_W, TG_RD, TG_RD_ACK} csp_tgt_t;
endpackage : csp_pkg

// >>> src/csp_host_if.sv
`timescale 1ns/10ps
`default_nettype none
interface csp_host_if;
   logic wr_stb;
   logic [7:0] reg_ptr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport target (output wr_stb, output reg_ptr, output wdata,
      input rdata);
   modport regs (input wr_stb, input reg_ptr, input wdata, output rdata);
endinterface : csp_host_if
`default_nettype wire

// >>> src/csp_serial_target.sv
`timescale 1ns/10ps
`default_nettype none
module csp_serial_target
   import csp_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_halt,
   input wire logic i_scl,
   input wire logic i_sda,
   input wire logic i_addr_sel,
   output logic o_sda_oe,
   csp_host_if.target bus
);
   csp_tgt_t st_q;
   logic [2:0] scl_s_q, sda_s_q;
   logic scl_q, sda_q, scl_p_q, sda_p_q;
   logic [2:0] sel_s_q;
   logic sel_q;
   logic [3:0] bit_q;
   logic [7:0] sh_q;
   logic rw_q;
   logic rise, fall, start, stop;

   // pins pass three flops; a level counts when the last two agree
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
      begin
         scl_s_q <= 3'h7;
         sda_s_q <= 3'h7;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_p_q <= 1'b1;
         sda_p_q <= 1'b1;
         sel_s_q <= 3'h0;
         sel_q <= 1'b0;
      end
      else
      begin
         scl_s_q <= {scl_s_q[1:0], i_scl};
         sda_s_q <= {sda_s_q[1:0], i_sda};
         if (scl_s_q[1] == scl_s_q[2]) scl_q <= scl_s_q[2];
         if (sda_s_q[1] == sda_s_q[2]) sda_q <= sda_s_q[2];
         scl_p_q <= scl_q;
         sda_p_q <= sda_q;
         sel_s_q <= {sel_s_q[1:0], i_addr_sel};
         if (sel_s_q[1] == sel_s_q[2]) sel_q <= sel_s_q[2];
      end

   assign rise = scl_q & ~scl_p_q;
   assign fall = ~scl_q & scl_p_q;
   assign start = scl_q & scl_p_q & sda_p_q & ~sda_q;
   assign stop = scl_q & scl_p_q & ~sda_p_q & sda_q;

   // byte engine; one register per transfer, no auto increment
   always_ff @(posedge i_clk or negedge i_nrst)
      if (!i_nrst)
      begin
         st_q <= TG_IDLE;
         bit_q <= 4'h0;
         sh_q <= 8'h00;
         rw_q <= 1'b0;
         o_sda_oe <= 1'b0;
         bus.reg_ptr <= 8'h00;
         bus.wdata <= 8'h00;
         bus.wr_stb <= 1'b0;
      end
      else if (i_halt)
      begin
         st_q <= TG_IDLE;
         o_sda_oe <= 1'b0;
         bus.wr_stb <= 1'b0;
      end
      else
      begin
         bus.wr_stb <= 1'b0;
         if (start)
         begin
            st_q <= TG_ADDR;
            bit_q <= 4'h0;
            o_sda_oe <= 1'b0;
         end
         else if (stop)
         begin
            st_q <= TG_IDLE;
            o_sda_oe <= 1'b0;
         end
         else if (rise)
         begin
            unique case (st_q)
               TG_ADDR, TG_PTR, TG_WDATA:
               begin
                  sh_q <= {sh_q[6:0], sda_q};
                  bit_q <= bit_q + 4'h1;
               end
               TG_RD: bit_q <= bit_q + 4'h1;
               TG_RD_ACK: st_q <= TG_IDLE; // either answer ends the read
               default: ;
            endcase
         end
         else if (fall)
         begin
            unique case (st_q)
               TG_ADDR:
                  if (bit_q == 4'h8)
                  begin
                     if (sh_q[7:1] == {TGT_ADDR_BASE[6:1], sel_q})
                     begin
                        rw_q <= sh_q[0];
                        o_sda_oe <= 1'b1;
                        st_q <= TG_ACK_A;
                     end
                     else st_q <= TG_IDLE;
                  end
               TG_ACK_A:
               begin
                  bit_q <= 4'h0;
                  if (rw_q)
                  begin
                     sh_q <= bus.rdata;
                     o_sda_oe <= ~bus.rdata[7];
                     st_q <= TG_RD;
                  end
                  else
                  begin
                     o_sda_oe <= 1'b0;
                     st_q <= TG_PTR;
                  end
               end
               TG_PTR:
                  if (bit_q == 4'h8)
                  begin
                     bus.reg_ptr <= sh_q;
                     o_sda_oe <= 1'b1;
                     st_q <= TG_ACK_P;
                  end
               TG_ACK_P:
               begin
                  bit_q <= 4'h0;
                  o_sda_oe <= 1'b0;
                  st_q <= TG_WDATA;
               end
               TG_WDATA:
                  if (bit_q == 4'h8)
                  begin
                     bus.wdata <= sh_q;
                     bus.wr_stb <= 1'b1;
                     o_sda_oe <= 1'b1;
                     st_q <= TG_ACK_W;
                  end
               TG_ACK_W:
               begin
                  o_sda_oe <= 1'b0;
                  st_q <= TG_IDLE;
               end
               TG_RD:
                  if (bit_q == 4'h8)
                  begin
                     o_sda_oe <= 1'b0;
                     st_q <= TG_RD_ACK;
                  end
                  else
                  begin
                     sh_q <= {sh_q[6:0], 1'b0};
                     o_sda_oe <= ~sh_q[6]; // open drain: drive only zeros
                  end
               default: ;
            endcase
         end
      end
endmodule : csp_serial_target
`default_nettype wire

// >>> tb/csp_scan_ctrl_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module csp_scan_ctrl_asserts
   import csp_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_NRST,
   input wire logic I_SHUTDOWN_INPUT,
   input wire logic I_SCL,
   input wire logic O_SDA_OE,
   input wire logic [3:0] O_CH_SEL,
   input wire logic O_AFE_SAMPLE,
   input wire logic O_ADC_START,
   input wire logic O_LOW_POWER,
   input wire logic O_INT,
   input wire logic [CH_NUM-1:0] O_TOUCH
);
   int settle_q;

   default clocking @(posedge I_CLK); endclocking
   default disable iff (!I_NRST);

   // length of the current settle run, read when the start pulse lands
   always_ff @(posedge I_CLK or negedge I_NRST)
   begin
      if (!I_NRST)
         settle_q <= 0;
      else if (O_AFE_SAMPLE)
         settle_q <= settle_q + 1;
      else
         settle_q <= 0;
   end

   settle_len_a:
   assert property (O_ADC_START |-> $past(O_AFE_SAMPLE)
      && settle_q == SETTLE_CYC) else $error("settle run wrong at start");
   start_pulse_a:
   assert property (O_ADC_START |=> !O_ADC_START [*8])
      else $error("start pulse too long or repeated");
   ch_step_a:
   assert property ($changed(O_CH_SEL) |-> O_CH_SEL == 4'h0
      || O_CH_SEL == 4'($past(O_CH_SEL) + 4'h1))
      else $error("channel left the ascending order");
   ch_hold_a:
   assert property (O_AFE_SAMPLE && $past(O_AFE_SAMPLE) |-> $stable(O_CH_SEL))
      else $error("channel moved during settle");
   halt_a:
   assert property (!I_SHUTDOWN_INPUT [*7] |-> !O_ADC_START && !O_AFE_SAMPLE
      && !O_LOW_POWER && O_TOUCH == '0) else $error("activity while halted");
   int_wake_a:
   assert property ($rose(O_INT) |-> $past(O_LOW_POWER) && !O_LOW_POWER)
      else $error("interrupt without wake");
   lp_exit_a:
   assert property ($fell(O_LOW_POWER) |-> O_INT || O_TOUCH == '0)
      else $error("low power left without wake or reset");
   lp_enter_a:
   assert property ($rose(O_LOW_POWER) |-> O_TOUCH == '0)
      else $error("low power entered while touched");
   sda_edge_a:
   assert property ($changed(O_SDA_OE) |-> !I_SCL)
      else $error("data line changed while serial clock high");
endmodule : csp_scan_ctrl_asserts
`default_nettype wire

// >>> tb/csp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module csp_host_model
(
   input wire logic i_clk,
   input wire logic i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   int q_len = 8;

   // bus idles released, clock high
   initial
   begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   // quarter bit; a larger q_len plays a slow host
   task automatic quarter();
      repeat (q_len) @(negedge i_clk);
   endtask : quarter
   task automatic start();
      o_sda_low = 1'b0;
      quarter();
      o_scl = 1'b1;
      quarter();
      o_sda_low = 1'b1;
      quarter();
      o_scl = 1'b0;
      quarter();
   endtask : start
   task automatic stop();
      o_sda_low = 1'b1;
      quarter();
      o_scl = 1'b1;
      quarter();
      o_sda_low = 1'b0;
      quarter();
   endtask : stop
   // data moves only while the clock is low, read mid high phase
   task automatic xfer_bit(input logic b, output logic s);
      o_sda_low = !b;
      quarter();
      o_scl = 1'b1;
      quarter();
      s = i_sda;
      quarter();
      o_scl = 1'b0;
      quarter();
   endtask : xfer_bit
   // msb first, ninth bit released: ack on write, nack on read
   task automatic xfer_byte(input logic [7:0] v, output logic [7:0] r,
      output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         xfer_bit(v[i], s);
         r[i] = s;
      end
      xfer_bit(1'b1, s);
      ack = !s;
   endtask : xfer_byte
   task automatic write_reg(input logic [6:0] a, input logic [7:0] p,
      input logic [7:0] d, output logic ok);
      logic [7:0] r;
      logic k1, k2, k3;
      start();
      xfer_byte({a, 1'b0}, r, k1);
      xfer_byte(p, r, k2);
      xfer_byte(d, r, k3);
      stop();
      ok = k1 & k2 & k3;
   endtask : write_reg
   // pointer write, repeated start, one byte back
   task automatic read_reg(input logic [6:0] a, input logic [7:0] p,
      output logic [7:0] d, output logic ok);
      logic k1, k2, k3, k4;
      start();
      xfer_byte({a, 1'b0}, d, k1);
      xfer_byte(p, d, k2);
      start();
      xfer_byte({a, 1'b1}, d, k3);
      xfer_byte(8'hFF, d, k4);
      stop();
      ok = k1 & k2 & k3;
   endtask : read_reg
endmodule : csp_host_model
`default_nettype wire

// >>> tb/csp_scan_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
module csp_scan_ctrl_test;
   import csp_pkg::*;
   logic clk, nrst, shdn, adc_done, ok;
   logic [CODE_W-1:0] adc_code;
   logic [CODE_W-1:0] code_tab [CH_NUM];
   wire logic sda, scl, host_low, sda_o, sda_oe, afe, start, lp, irq;
   wire logic [3:0] ch;
   wire logic [CH_NUM-1:0] touch;
   logic [7:0] rd;
   logic [31:0] rng = 32'h0000_005A;
   logic [6:0] adr;
   int bad_count, cmp_count, i, nxt;
   logic [3:0] exp_q [$];

   csp_scan_ctrl #(.SLEEP_GAP(20), .QUIET_N(2)) dut (
      .I_CLK(clk), .I_NRST(nrst), .I_SHUTDOWN_INPUT(shdn), .I_SCL(scl),
      .I_SDA_I(sda), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_ADDR_SEL(1'b1),
      .I_ADC_DONE(adc_done), .I_ADC_CODE(adc_code), .O_CH_SEL(ch),
      .O_AFE_SAMPLE(afe), .O_ADC_START(start), .O_LOW_POWER(lp),
      .O_INT(irq), .O_TOUCH(touch));
   csp_host_model host (.i_clk(clk), .i_sda(sda), .o_scl(scl),
      .o_sda_low(host_low));
   // open-drain wire with pull-up
   assign sda = !host_low && !(sda_oe && !sda_o);

   initial
   begin
      clk = 1'b0;
      forever #4 clk = !clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction : xs
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_sim
   // after a reset the scan restarts at channel 0; let any late answer pass
   task automatic rescan();
      repeat (10) @(negedge clk);
      exp_q = {4'h0};
      nxt = 0;
   endtask : rescan
   // converter stand-in, answers each start after 1..4 cycles
   initial
   begin
      adc_done = 1'b0;
      adc_code = '0;
      forever
      begin
         @(negedge clk);
         if (start === 1'b1)
         begin
            rng = xs(rng);
            repeat (int'(rng[1:0]) + 1) @(negedge clk);
            adc_code = code_tab[ch];
            adc_done = 1'b1;
            nxt = (nxt + 1) % CH_NUM;
            exp_q.push_back(4'(nxt));
            @(negedge clk);
            adc_done = 1'b0;
            adc_code = ~adc_code; // code is only valid beside done
         end
      end
   end
   // every start is matched against the oldest predicted channel
   always @(negedge clk)
      if (start === 1'b1)
         check(16'(ch), exp_q.size() ? 16'(exp_q.pop_front()) : 16'hFFFF);
   initial
   begin
      repeat (99000) @(posedge clk);
      bad_count++;
      end_sim();
   end
   initial
   begin
      nrst = 1'b0;
      shdn = 1'b1;
      adr = TGT_ADDR_BASE | 7'h01;
      for (i = 0; i < CH_NUM; i++)
      begin
         rng = xs(rng);
         code_tab[i] = 10'h040 + 10'(rng[7:0]);
      end
      exp_q = {4'h0};
      nxt = 0;
      repeat (5) @(negedge clk);
      check(touch, 16'h0000);
      check({13'h0, lp, irq, sda_oe}, 16'h0000);
      nrst = 1'b1;
      // baseline scan, then one quiet scan brings low power
      for (i = 0; i < 20000 && lp !== 1'b1; i++) @(negedge clk);
      check({15'h0, lp}, 16'h0001);
      code_tab[3] = code_tab[3] + 10'h080;
      for (i = 0; i < 30000 && irq !== 1'b1; i++) @(negedge clk);
      check({14'h0, lp, irq}, 16'h0001);
      check(touch, 16'h0008);
      host.read_reg(adr, RA_TOUCH_LO, rd, ok);
      check({7'h0, ok, rd}, 16'h0108);
      host.read_reg(adr, RA_DELTA_BASE + 8'h03, rd, ok);
      check({7'h0, ok, rd}, 16'h0120);
      host.q_len = 20;
      host.read_reg(adr, RA_STATUS, rd, ok);
      check({7'h0, ok, 6'h0, rd[1:0]}, 16'h0102);
      host.q_len = 8;
      host.read_reg(adr, 8'h20, rd, ok);
      check({7'h0, ok, rd}, 16'h0100);
      host.write_reg(7'h33, RA_CTRL, 8'h01, ok);
      check({7'h0, ok, touch[7:0]}, 16'h0008);
      host.write_reg(adr, RA_CTRL, 8'h02, ok);
      repeat (4) @(negedge clk);
      check({7'h0, ok, 7'h0, irq}, 16'h0100);
      code_tab[3] = code_tab[3] - 10'h080;
      for (i = 0; i < 20000 && touch !== 16'h0000; i++) @(negedge clk);
      check(touch, 16'h0000);
      code_tab[5] = code_tab[5] + 10'h080;
      code_tab[12] = code_tab[12] + 10'h080;
      for (i = 0; i < 30000 && touch !== 16'h1020; i++) @(negedge clk);
      check(touch, 16'h1020);
      host.write_reg(adr, RA_THRESH, 8'h30, ok);
      host.read_reg(adr, RA_THRESH, rd, ok);
      check({7'h0, ok, rd}, 16'h0130);
      host.write_reg(adr, RA_CTRL, 8'h01, ok);
      code_tab[5] = code_tab[5] - 10'h080;
      code_tab[12] = code_tab[12] - 10'h080;
      rescan();
      check({ok, 13'h0, lp, irq}, 16'h8000);
      check(touch, 16'h0000);
      host.read_reg(adr, RA_THRESH, rd, ok);
      check({7'h0, ok, rd}, {8'h01, RST_THRESH});
      shdn = 1'b0;
      rescan();
      repeat (200) @(negedge clk);
      check({ch, 8'h0, afe, start, lp, irq}, 16'h0000);
      shdn = 1'b1;
      for (i = 0; i < 2000 && start !== 1'b1; i++) @(negedge clk);
      check({15'h0, start}, 16'h0001);
      repeat (20) @(negedge clk);
      end_sim();
   end
endmodule : csp_scan_ctrl_test

bind csp_scan_ctrl csp_scan_ctrl_asserts u_chk (
   .I_CLK(I_CLK), .I_NRST(I_NRST), .I_SHUTDOWN_INPUT(I_SHUTDOWN_INPUT),
   .I_SCL(I_SCL), .O_SDA_OE(O_SDA_OE), .O_CH_SEL(O_CH_SEL),
   .O_AFE_SAMPLE(O_AFE_SAMPLE), .O_ADC_START(O_ADC_START),
   .O_LOW_POWER(O_LOW_POWER), .O_INT(O_INT), .O_TOUCH(O_TOUCH));
`default_nettype wire
